// *** wcto_params.svh ***
`ifndef WCTO_PARAMS_SVH
`define WCTO_PARAMS_SVH
// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define WCTO_IDX_CH2_BH   8'h20
`define WCTO_IDX_CH3_TH   8'h21
`define WCTO_IDX_CH3_BL   8'h22
`define WCTO_IDX_CH3_BH   8'h23
`define WCTO_IDX_SAT      8'h24
`define WCTO_IDX_LOT      8'h25
`define WCTO_IDX_SRCH     8'h26
`define WCTO_IDX_SYNC     8'h27
`define WCTO_IDX_CTRL     8'h2F
`define WCTO_IDX_STAT     8'h30
// ****************************************
// Reset values
// ****************************************
`define WCTO_RST_CH2_BH   8'h00
`define WCTO_RST_CH3_TH   8'h00
`define WCTO_RST_CH3_BL   8'hFF
`define WCTO_RST_CH3_BH   8'h00
`define WCTO_RST_SAT      8'h10
`define WCTO_RST_LOT      8'h00
`define WCTO_RST_SRCH     8'h87
`define WCTO_RST_SYNC     8'hFF
`define WCTO_RST_CTRL     8'h00
// ****************************************
// Field positions
// ****************************************
`define WCTO_LOT_PS_MSB   7
`define WCTO_LOT_PS_LSB   5
`define WCTO_LOT_N_MSB    4
`define WCTO_LOT_N_LSB    0
`define WCTO_CTRL_RECOG   0
// ****************************************
// Timing, in system clock periods
// ****************************************
`define WCTO_LOT_PS_BASE  4
`define WCTO_LOT_N_ZERO   32
`define WCTO_LOT_UNIT     64
`define WCTO_SYNC_PS      512
`define WCTO_SYNC_UNIT    (`WCTO_LOT_UNIT * `WCTO_SYNC_PS)
`endif

// *** wcto_pkg.sv ***
package wcto_pkg;
   // Timer state of the symbol-sync timeout
   typedef enum logic [2:0] {
      WCTO_IDLE = 3'b001,
      WCTO_RUN  = 3'b010,
      WCTO_HELD = 3'b100
   } wcto_state_type;
   typedef logic [7:0] wcto_byte_type;
endpackage

// *** wcto_top.sv ***
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "wcto_params.svh"
// How it works
// RQ1: Channel 3 wakes above strength threshold
// RQ2: High blocking register is upper strength block
// RQ3: Recognition wake needs N consecutive high samples
// RQ4: Low blocking level, channel 3 resets FF
// RQ5: Saturation threshold register, reset 10h
// RQ6: Prescaler code selects 4 doubling to 512
// RQ7: Observation time N x prescaler x 64
// RQ8: Observation count zero means 32
// RQ9: Sync search limit sixteenths, reset 87h
// RQ10: Sync timeout expiry returns to self polling
// RQ11: Timeout setting x 64 x 512, zero disables
// RQ12: Timeout timer restarts each run cycle
module wcto_top #(
   parameter int SYNC_UNIT = `WCTO_SYNC_UNIT
) (
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire logic                   hsel_i,
   input  wire logic [31:0]            haddr_i,
   input  wire logic [1:0]             htrans_i,
   input  wire logic                   hwrite_i,
   input  wire logic [2:0]             hsize_i,
   input  wire logic                   hready_i,
   input  wire logic [31:0]            hwdata_i,
   output logic      [31:0]            hrdata_o,
   output logic                        hreadyout_o,
   output logic                        hresp_o,
   input  wire wcto_pkg::wcto_byte_type rssi_level_i,
   input  wire logic [1:0]             sig_recog_i,
   input  wire logic                   sample_stb_i,
   input  wire logic                   lot_start_i,
   input  wire logic                   rmsp_start_i,
   input  wire logic                   sym_sync_i,
   output logic                        ch3_wake_o,
   output logic                        ch3_blocked_o,
   output logic [1:0]                  recog_event_o,
   output wcto_pkg::wcto_byte_type     peak_detector_saturation_o,
   output wcto_pkg::wcto_byte_type     sync_search_limit_o,
   output logic                        lot_busy_o,
   output logic                        lot_done_o,
   output logic                        rmsp_exit_o
);
   import wcto_pkg::*;

   // ****************************************
   // Configuration registers
   // ****************************************
   wcto_byte_type  chan2_block_high_level_ff;
   wcto_byte_type  chan3_wake_threshold_ff;
   wcto_byte_type  chan3_block_low_level_ff;
   wcto_byte_type  chan3_block_high_level_ff;
   wcto_byte_type  peak_detector_saturation_ff;
   wcto_byte_type  level_observation_ff;
   wcto_byte_type  sync_search_limit_ff;
   wcto_byte_type  sync_timeout_setting_ff;
   wcto_byte_type  ctrl_ff;
   logic           recog_mode;

   // ****************************************
   // Bus slave state
   // ****************************************
   logic           take;
   logic           wr_pend_ff;
   logic [7:0]     wr_idx_ff;
   logic [7:0]     rd_idx;
   logic [31:0]    hrdata_ff;
   logic           hreadyout_ff;
   logic           hresp_ff;

   // Word index; any high address bit set lands off the map
   function automatic logic [7:0] word_idx(input logic [31:0] a);
      word_idx = (a[31:10] == 22'd0) ? a[9:2] : 8'hFF;
   endfunction

   function automatic logic writable(input logic [7:0] i);
      writable = (i >= `WCTO_IDX_CH2_BH && i <= `WCTO_IDX_SYNC) ||
                 (i == `WCTO_IDX_CTRL);
   endfunction

   assign take       = hsel_i & hready_i & htrans_i[1];
   assign rd_idx     = word_idx(haddr_i);
   assign recog_mode = ctrl_ff[`WCTO_CTRL_RECOG];

   // Capture the address phase of a write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_pend_ff <= 1'b0;
         wr_idx_ff  <= 8'h00;
      end else begin
         wr_pend_ff <= take & hwrite_i;
         wr_idx_ff  <= rd_idx;
      end
   end

   // Write data phase; unmapped indices are dropped silently
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chan2_block_high_level_ff   <= `WCTO_RST_CH2_BH;
         chan3_wake_threshold_ff     <= `WCTO_RST_CH3_TH;
         chan3_block_low_level_ff    <= `WCTO_RST_CH3_BL; // RQ4
         chan3_block_high_level_ff   <= `WCTO_RST_CH3_BH;
         peak_detector_saturation_ff <= `WCTO_RST_SAT;    // RQ5
         level_observation_ff        <= `WCTO_RST_LOT;
         sync_search_limit_ff        <= `WCTO_RST_SRCH;   // RQ9
         sync_timeout_setting_ff     <= `WCTO_RST_SYNC;   // RQ11
         ctrl_ff                     <= `WCTO_RST_CTRL;
      end else if (wr_pend_ff) begin
         unique case (wr_idx_ff)
            `WCTO_IDX_CH2_BH: chan2_block_high_level_ff   <= hwdata_i[7:0];
            `WCTO_IDX_CH3_TH: chan3_wake_threshold_ff     <= hwdata_i[7:0];
            `WCTO_IDX_CH3_BL: chan3_block_low_level_ff    <= hwdata_i[7:0];
            `WCTO_IDX_CH3_BH: chan3_block_high_level_ff   <= hwdata_i[7:0];
            `WCTO_IDX_SAT:    peak_detector_saturation_ff <= hwdata_i[7:0];
            `WCTO_IDX_LOT:    level_observation_ff        <= hwdata_i[7:0];
            `WCTO_IDX_SRCH:   sync_search_limit_ff        <= hwdata_i[7:0];
            `WCTO_IDX_SYNC:   sync_timeout_setting_ff     <= hwdata_i[7:0];
            `WCTO_IDX_CTRL:   ctrl_ff                     <= hwdata_i[7:0];
            default: ;
         endcase
      end
   end

   // Status word built from the block's live flops
   wcto_state_type state_ff;
   logic [7:0]     status;
   assign status = {1'b0, state_ff == WCTO_HELD, state_ff == WCTO_RUN,
                    lot_busy_o, recog_event_o, ch3_blocked_o, ch3_wake_o};

   function automatic logic [7:0] reg_mux(input logic [7:0] i);
      unique case (i)
         `WCTO_IDX_CH2_BH: reg_mux = chan2_block_high_level_ff;
         `WCTO_IDX_CH3_TH: reg_mux = chan3_wake_threshold_ff;
         `WCTO_IDX_CH3_BL: reg_mux = chan3_block_low_level_ff;
         `WCTO_IDX_CH3_BH: reg_mux = chan3_block_high_level_ff;
         `WCTO_IDX_SAT:    reg_mux = peak_detector_saturation_ff;
         `WCTO_IDX_LOT:    reg_mux = level_observation_ff;
         `WCTO_IDX_SRCH:   reg_mux = sync_search_limit_ff;
         `WCTO_IDX_SYNC:   reg_mux = sync_timeout_setting_ff;
         `WCTO_IDX_CTRL:   reg_mux = ctrl_ff;
         `WCTO_IDX_STAT:   reg_mux = status;
         default:          reg_mux = 8'h00;
      endcase
   endfunction

   // Read data registered at the address phase; a write still in its
   // data phase is forwarded so back-to-back write/read sees new data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (take & ~hwrite_i) begin
         if (wr_pend_ff && wr_idx_ff == rd_idx && writable(rd_idx)) begin
            hrdata_ff <= {24'h00_0000, hwdata_i[7:0]};
         end else begin
            hrdata_ff <= {24'h00_0000, reg_mux(rd_idx)};
         end
      end
   end

   // Zero wait state, always OKAY
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hreadyout_ff <= 1'b1;
         hresp_ff     <= 1'b0;
      end else begin
         hreadyout_ff <= 1'b1;
         hresp_ff     <= 1'b0;
      end
   end

   assign hrdata_o                   = hrdata_ff;
   assign hreadyout_o                = hreadyout_ff;
   assign hresp_o                    = hresp_ff;
   assign peak_detector_saturation_o = peak_detector_saturation_ff; // RQ5
   assign sync_search_limit_o        = sync_search_limit_ff;        // RQ9

   // ****************************************
   // Signal strength wake and blocking, channel 3
   // ****************************************
   logic ch3_wake_ff;
   logic ch3_blocked_ff;
   logic nxt_blocked;
   assign nxt_blocked = rssi_level_i >= chan3_block_low_level_ff &&
                        rssi_level_i <= chan3_block_high_level_ff; // RQ2 RQ4

   // Reset levels give an empty blocking window
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ch3_wake_ff    <= 1'b0;
         ch3_blocked_ff <= 1'b0;
      end else begin
         ch3_blocked_ff <= ~recog_mode & nxt_blocked;
         ch3_wake_ff    <= ~recog_mode & ~nxt_blocked &
                           (rssi_level_i > chan3_wake_threshold_ff); // RQ1
      end
   end
   assign ch3_wake_o    = ch3_wake_ff;
   assign ch3_blocked_o = ch3_blocked_ff;

   // ****************************************
   // Recognition run counters, channels 2 and 3
   // ****************************************
   logic [7:0] recog_run_ff [2];
   logic [1:0] recog_event_ff;
   wcto_byte_type recog_min [2];
   assign recog_min[0] = chan2_block_high_level_ff;
   assign recog_min[1] = chan3_block_high_level_ff;

   // A zero minimum still asks for one high sample
   for (genvar c = 0; c < 2; c++) begin : g_recog
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            recog_run_ff[c] <= 8'h00;
         end else if (sample_stb_i) begin
            if (!sig_recog_i[c]) begin
               recog_run_ff[c] <= 8'h00;
            end else if (recog_run_ff[c] != 8'hFF) begin
               recog_run_ff[c] <= recog_run_ff[c] + 8'h01;
            end
         end
      end
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            recog_event_ff[c] <= 1'b0;
         end else begin
            recog_event_ff[c] <= recog_mode && recog_run_ff[c] != 8'h00 &&
                                 recog_run_ff[c] >= recog_min[c]; // RQ3
         end
      end
   end
   assign recog_event_o = recog_event_ff;

   // ****************************************
   // Level observation timer
   // ****************************************
   logic [20:0] lot_cnt_ff;
   logic [20:0] lot_tgt_ff;
   logic        lot_busy_ff;
   logic        lot_done_ff;

   function automatic logic [20:0] lot_cycles(input logic [7:0] v);
      logic [5:0] n;
      logic [2:0] ps;
      n  = (v[`WCTO_LOT_N_MSB:`WCTO_LOT_N_LSB] == 5'd0) ? 6'(`WCTO_LOT_N_ZERO)
                                                        : 6'(v[4:0]); // RQ8
      ps = v[`WCTO_LOT_PS_MSB:`WCTO_LOT_PS_LSB];
      lot_cycles = 21'(n) * (21'(`WCTO_LOT_PS_BASE) << ps) // RQ6
                   * 21'(`WCTO_LOT_UNIT);                   // RQ7
   endfunction

   // Target latched at start so a rewrite cannot cut a running window
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lot_busy_ff <= 1'b0;
         lot_done_ff <= 1'b0;
         lot_cnt_ff  <= 21'd0;
         lot_tgt_ff  <= 21'd0;
      end else if (lot_start_i) begin
         lot_busy_ff <= 1'b1;
         lot_done_ff <= 1'b0;
         lot_cnt_ff  <= 21'd1;
         lot_tgt_ff  <= lot_cycles(level_observation_ff);
      end else begin
         lot_done_ff <= lot_busy_ff && lot_cnt_ff == lot_tgt_ff; // RQ7
         if (lot_busy_ff && lot_cnt_ff == lot_tgt_ff) begin
            lot_busy_ff <= 1'b0;
         end
         lot_cnt_ff <= lot_busy_ff ? lot_cnt_ff + 21'd1 : 21'd0;
      end
   end
   assign lot_busy_o = lot_busy_ff;
   assign lot_done_o = lot_done_ff;

   // ****************************************
   // Symbol-sync timeout timer
   // ****************************************
   logic [22:0]    sync_cnt_ff;
   logic [22:0]    sync_lim;
   logic           rmsp_exit_ff;
   assign sync_lim = 23'(sync_timeout_setting_ff) * 23'(SYNC_UNIT); // RQ11

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff     <= WCTO_IDLE;
         sync_cnt_ff  <= 23'd0;
         rmsp_exit_ff <= 1'b0;
      end else if (rmsp_start_i) begin
         // Zero setting keeps the timer off
         state_ff     <= (sync_lim != 23'd0) ? WCTO_RUN : WCTO_IDLE; // RQ11
         sync_cnt_ff  <= 23'd0;                                       // RQ12
         rmsp_exit_ff <= 1'b0;
      end else begin
         rmsp_exit_ff <= 1'b0;
         unique case (state_ff)
            WCTO_IDLE: ;
            WCTO_RUN: begin
               if (sym_sync_i) begin
                  state_ff <= WCTO_HELD;
               end else if (sync_cnt_ff + 23'd1 >= sync_lim) begin
                  state_ff     <= WCTO_IDLE;
                  rmsp_exit_ff <= 1'b1; // RQ10
               end else begin
                  sync_cnt_ff <= sync_cnt_ff + 23'd1;
               end
            end
            WCTO_HELD: ;
            default: state_ff <= WCTO_IDLE;
         endcase
      end
   end
   assign rmsp_exit_o = rmsp_exit_ff;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_wake_thresh: assert property ( // RQ1
      ch3_wake_o |-> $past(rssi_level_i) > $past(chan3_wake_threshold_ff))
      else $error("wake without level above threshold");

   chk_block_high: assert property ( // RQ2
      ch3_blocked_o |-> $past(rssi_level_i) <= $past(chan3_block_high_level_ff))
      else $error("blocked above high level");

   chk_recog_run: assert property ( // RQ3
      (recog_mode && sample_stb_i && !sig_recog_i[1]) ##1 recog_mode
      |=> !recog_event_o[1])
      else $error("recognition event after low sample");

   chk_reset_vals: assert property ( // RQ4
      $past(rst_i) |-> chan3_block_low_level_ff == 8'hFF &&
      peak_detector_saturation_ff == 8'h10 &&
      sync_search_limit_ff == 8'h87 && sync_timeout_setting_ff == 8'hFF)
      else $error("reset value wrong");

   chk_sat_out: assert property ( // RQ5
      wr_pend_ff && wr_idx_ff == `WCTO_IDX_SAT
      |=> peak_detector_saturation_o == $past(hwdata_i[7:0]))
      else $error("saturation threshold not updated");

   chk_lot_target: assert property ( // RQ6
      lot_start_i |=> lot_tgt_ff ==
      21'(((level_observation_ff[4:0] == 5'd0) ? 32 : level_observation_ff[4:0])
          * (4 << level_observation_ff[7:5]) * 64))
      else $error("observation length wrong");

   chk_lot_zero: assert property ( // RQ8
      lot_start_i && level_observation_ff == 8'h00 |=> lot_tgt_ff == 21'd8192)
      else $error("zero count not read as 32");

   chk_lot_done: assert property ( // RQ7
      lot_done_o |-> $past(lot_cnt_ff) == $past(lot_tgt_ff) && !lot_busy_o)
      else $error("observation ended early");

   chk_exit_cause: assert property ( // RQ10
      rmsp_exit_o |-> $past(!sym_sync_i) && $past(state_ff == WCTO_RUN))
      else $error("exit while sync present");

   chk_zero_off: assert property ( // RQ11
      rmsp_start_i && sync_timeout_setting_ff == 8'h00 |=> state_ff == WCTO_IDLE)
      else $error("zero setting did not disable");

   chk_timer_restart: assert property ( // RQ12
      rmsp_start_i && sync_timeout_setting_ff != 8'h00
      |=> sync_cnt_ff == 23'd0 && state_ff == WCTO_RUN)
      else $error("timer not restarted");

   cov_exit: cover property (state_ff == WCTO_RUN ##1 rmsp_exit_o);
   cov_held: cover property (state_ff == WCTO_RUN ##1 state_ff == WCTO_HELD);
   cov_recog: cover property (recog_mode ##1 recog_event_o[1]);
   cov_lot: cover property (lot_start_i ##[1:1000] lot_done_o);
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
`include "wcto_params.svh"
// ******
// Bench for the wake-up criteria and timeout block
// ******
module tb_top;
   import wcto_pkg::*;
   // Short timeout unit keeps the sync tests brief
   localparam int SYNC_UNIT = 4;
   localparam logic [7:0] RIDX [10] = '{`WCTO_IDX_CH2_BH, `WCTO_IDX_CH3_TH, `WCTO_IDX_CH3_BL,
      `WCTO_IDX_CH3_BH, `WCTO_IDX_SAT, `WCTO_IDX_LOT, `WCTO_IDX_SRCH, `WCTO_IDX_SYNC,
      `WCTO_IDX_CTRL, 8'h3F};
   localparam logic [7:0] RVAL [10] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h10, 8'h00, 8'h87,
      8'hFF, 8'h00, 8'h00};
   logic          clk_i = 1'b0;
   logic          rst_i = 1'b1;
   logic          hsel_i = 1'b0;
   logic [31:0]   haddr_i = 32'h0000_0000;
   logic [1:0]    htrans_i = 2'b00;
   logic          hwrite_i = 1'b0;
   logic [31:0]   hwdata_i = 32'h0000_0000;
   wcto_byte_type rssi_level_i = 8'h00;
   logic [1:0]    sig_recog_i = 2'b00;
   logic          sample_stb_i = 1'b0;
   logic          lot_start_i = 1'b0;
   logic          rmsp_start_i = 1'b0;
   logic          sym_sync_i = 1'b0;
   logic [31:0]   hrdata_o;
   logic          hreadyout_o;
   logic          hresp_o;
   logic [1:0]    recog_event_o;
   wcto_byte_type sat_o;
   wcto_byte_type srch_o;
   logic          ch3_wake_o;
   logic          ch3_blocked_o;
   logic          lot_busy_o;
   logic          lot_done_o;
   logic          rmsp_exit_o;
   int            err_count = 0;
   int            checked = 0;
   int            n;

   // Clock at 250 MHz
   always #2 clk_i = ~clk_i;

   // Single slave, so its ready closes the loop back to hready
   wcto_top #(.SYNC_UNIT(SYNC_UNIT)) u_dut (
      .clk_i                      (clk_i),
      .rst_i                      (rst_i),
      .hsel_i                     (hsel_i),
      .haddr_i                    (haddr_i),
      .htrans_i                   (htrans_i),
      .hwrite_i                   (hwrite_i),
      .hsize_i                    (3'b010),
      .hready_i                   (hreadyout_o),
      .hwdata_i                   (hwdata_i),
      .hrdata_o                   (hrdata_o),
      .hreadyout_o                (hreadyout_o),
      .hresp_o                    (hresp_o),
      .rssi_level_i               (rssi_level_i),
      .sig_recog_i                (sig_recog_i),
      .sample_stb_i               (sample_stb_i),
      .lot_start_i                (lot_start_i),
      .rmsp_start_i               (rmsp_start_i),
      .sym_sync_i                 (sym_sync_i),
      .ch3_wake_o                 (ch3_wake_o),
      .ch3_blocked_o              (ch3_blocked_o),
      .recog_event_o              (recog_event_o),
      .peak_detector_saturation_o (sat_o),
      .sync_search_limit_o        (srch_o),
      .lot_busy_o                 (lot_busy_o),
      .lot_done_o                 (lot_done_o),
      .rmsp_exit_o                (rmsp_exit_o)
   );

   // ******
   // Reporting
   // ******
   task automatic complete_run;
      if (err_count == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // ******
   // Bus access
   // ******
   // Bounded wait for ready, a hang ends the run
   task automatic wait_ready;
      int k;
      k = 0;
      @(posedge clk_i);
      while (hreadyout_o !== 1'b1) begin
         k++;
         if (k > 50) begin
            err_count++;
            complete_run();
         end
         @(posedge clk_i);
      end
   endtask

   task automatic ahb_xfer(input logic [7:0] idx, input logic wr_en, input logic [31:0] wd,
                           output logic [31:0] rd);
      @(posedge clk_i);
      hsel_i <= 1'b1;
      htrans_i <= 2'b10;
      haddr_i <= {22'h0, idx, 2'b00};
      hwrite_i <= wr_en;
      wait_ready();
      hsel_i <= 1'b0;
      htrans_i <= 2'b00;
      hwdata_i <= wd;
      wait_ready();
      rd = hrdata_o;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] x;
      ahb_xfer(idx, 1'b1, d, x);
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] x;
      ahb_xfer(idx, 1'b0, 32'h0000_0000, x);
      chk(x, exp);
      // Slave must always answer OKAY
      chk({31'h0, hresp_o}, 32'h0000_0000);
   endtask

   // ******
   // Block stimulus
   // ******
   // One-cycle start pulse; returns on the edge that takes it
   task automatic pulse(input logic sel);
      @(posedge clk_i);
      if (sel) begin
         rmsp_start_i <= 1'b1;
      end else begin
         lot_start_i <= 1'b1;
      end
      @(posedge clk_i);
      rmsp_start_i <= 1'b0;
      lot_start_i <= 1'b0;
   endtask

   // Edges until done or exit; zero when it never came
   task automatic meas(input logic sel, input int lim, output int cnt);
      cnt = 0;
      do begin
         @(posedge clk_i);
         #1;
         cnt++;
      end while ((sel ? rmsp_exit_o : lot_done_o) !== 1'b1 && cnt < lim);
      if ((sel ? rmsp_exit_o : lot_done_o) !== 1'b1) begin
         cnt = 0;
      end
   endtask

   task automatic set_rssi(input logic [7:0] v, input logic wk, input logic blk);
      @(posedge clk_i);
      rssi_level_i <= v;
      repeat (2) @(posedge clk_i);
      #1;
      chk({30'h0, ch3_wake_o, ch3_blocked_o}, {30'h0, wk, blk});
   endtask

   task automatic strobe(input logic [1:0] rec, input logic [1:0] exp);
      @(posedge clk_i);
      sig_recog_i <= rec;
      sample_stb_i <= 1'b1;
      @(posedge clk_i);
      sample_stb_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      chk({30'h0, recog_event_o}, {30'h0, exp});
   endtask

   task automatic lot_run(input logic [2:0] ps, input logic [4:0] cnt);
      int len;
      int m;
      len = ((cnt == 5'd0) ? 32 : int'(cnt)) * (4 << ps) * 64;
      wr(`WCTO_IDX_LOT, {24'h0, ps, cnt});
      pulse(1'b0);
      meas(1'b0, len + 20, m);
      chk(32'(m), 32'(len));
      chk({31'h0, lot_busy_o}, 32'h0000_0000);
   endtask

   task automatic sync_run(input logic [7:0] s, input int hold_at, input int exp);
      int m;
      wr(`WCTO_IDX_SYNC, {24'h0, s});
      pulse(1'b1);
      if (hold_at > 0) begin
         repeat (hold_at) @(posedge clk_i);
         sym_sync_i <= 1'b1;
      end
      meas(1'b1, 60, m);
      @(posedge clk_i);
      sym_sync_i <= 1'b0;
      chk(32'(m), 32'(exp));
   endtask

   // ******
   // Main sequence
   // ******
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      // Reset values, unmapped index last
      for (int i = 0; i < 10; i++) begin
         rd_chk(RIDX[i], {24'h0, RVAL[i]});
      end
      chk({sat_o, srch_o}, {8'h10, 8'h87});
      // Reset setting of all ones times the unit
      pulse(1'b1);
      meas(1'b1, 1100, n);
      chk(32'(n), 32'(255 * SYNC_UNIT));
      // Only the low byte is kept
      for (int i = 0; i < 9; i++) begin
         wr(RIDX[i], {24'hFF_FFFF, 8'h5A ^ 8'(i)});
         rd_chk(RIDX[i], {24'h0, 8'h5A ^ 8'(i)});
      end
      chk({sat_o, srch_o}, {8'h5E, 8'h5C});
      wr(8'h3F, 32'h0000_00FF);
      rd_chk(8'h3F, 32'h0000_0000);
      // Strength mode: threshold and the blocking window edges
      wr(`WCTO_IDX_CTRL, 32'h0000_0000);
      wr(`WCTO_IDX_CH3_TH, 32'h0000_0040);
      wr(`WCTO_IDX_CH3_BL, 32'h0000_0050);
      wr(`WCTO_IDX_CH3_BH, 32'h0000_0060);
      set_rssi(8'h40, 1'b0, 1'b0);
      set_rssi(8'h41, 1'b1, 1'b0);
      set_rssi(8'h50, 1'b0, 1'b1);
      set_rssi(8'h4F, 1'b1, 1'b0);
      set_rssi(8'h61, 1'b1, 1'b0);
      set_rssi(8'h60, 1'b0, 1'b1);
      // Status cannot be written
      wr(`WCTO_IDX_STAT, 32'h0000_00FF);
      rd_chk(`WCTO_IDX_STAT, 32'h0000_0002);
      // Recognition mode: high levels become sample counts
      wr(`WCTO_IDX_CTRL, 32'h0000_0001);
      wr(`WCTO_IDX_CH2_BH, 32'h0000_0002);
      wr(`WCTO_IDX_CH3_BH, 32'h0000_0003);
      strobe(2'b11, 2'b00);
      strobe(2'b11, 2'b01);
      strobe(2'b11, 2'b11);
      strobe(2'b01, 2'b01);
      chk({31'h0, ch3_wake_o}, 32'h0000_0000);
      // Observation time for every prescaler code
      for (int k = 0; k < 8; k++) begin
         lot_run(3'(k), 5'd1);
      end
      lot_run(3'd1, 5'd3);
      lot_run(3'd0, 5'd0);
      // Sync timeout: count, disable, sync found, restart
      sync_run(8'h03, 0, 3 * SYNC_UNIT);
      sync_run(8'h00, 0, 0);
      sync_run(8'h02, 3, 0);
      // Held timer and the channel 2 recognition event show in status
      rd_chk(`WCTO_IDX_STAT, 32'h0000_0044);
      sync_run(8'h02, 0, 2 * SYNC_UNIT);
      wr(`WCTO_IDX_SYNC, 32'h0000_0003);
      pulse(1'b1);
      repeat (5) @(posedge clk_i);
      pulse(1'b1);
      meas(1'b1, 60, n);
      chk(32'(n), 32'(3 * SYNC_UNIT));
      complete_run();
   end
endmodule
